// *** common/asp_pkg.sv ***
/*
 * Constants and carrier types for the converter's serial port and control pins.
 * Assumes one system clock far faster than the serial clock, which is sampled as a plain input.
 */
//
// Contract
// - Serial clock and data are heeded only while chip select is low.
// - Serial data output is undriven while chip select is high.
// - Input bits are valid and captured on rising serial clock edges.
// - Serial data output changes on falling serial clock edges.
// - End-of-conversion goes low once result data is valid; master waits for it.
// - Top analog pin is either analog channel or active-low conversion start, never both.
// - Each conversion yields a 10-bit result.
// - Sixteen single-ended channels or eight adjacent differential pairs, by configuration.
// - Single-ended is always unipolar; differential pairs may be unipolar or bipolar.
// - Each transaction opens with an MSB-first command byte; range byte may follow.
// - End-of-conversion rises on chip select or start fall; stays high in mode 11.
// - Clock mode comes from setup bits 5 and 4.
package asp_pkg;
    localparam int          RES_W        = 10;
    localparam int          CHAN_W       = 4;
    localparam int          PAIR_N       = 8;
    localparam int          WORD_W       = 16;
    localparam int          LEAD_ZEROS   = 4;
    localparam int          SUB_BITS     = 2;
    // Command byte layout
    localparam int          CMD_CONV_BIT = 7;
    localparam int          CMD_SETUP_BIT = 6;
    localparam int          CHAN_LSB     = 3;
    localparam int          MODE_LSB     = 4;
    localparam int          TOP_PIN_BIT  = 3;
    localparam int          RSEL_LSB     = 0;
    localparam logic [2:0]  LAST_BIT     = 3'h7;
    localparam logic [4:0]  LAST_OUT_BIT = 5'h0F;
    localparam logic [3:0]  TOP_CHAN     = 4'hF;
    // Clock modes
    localparam logic [1:0]  MODE_PIN_SCAN = 2'h0;
    localparam logic [1:0]  MODE_PIN_EACH = 2'h1;
    localparam logic [1:0]  MODE_SERIAL   = 2'h2;
    localparam logic [1:0]  MODE_EXTCLK   = 2'h3;
    // Range register selection
    localparam logic [1:0]  RSEL_UNI     = 2'h1;
    localparam logic [1:0]  RSEL_BIP     = 2'h2;
    // Reset values and synchroniser depth
    localparam logic [1:0]  MODE_RESET   = MODE_SERIAL;
    localparam logic [7:0]  RANGE_RESET  = 8'h00;
    localparam int          SYNC_STAGES  = 2;

    typedef struct packed {
        logic              start;
        logic [CHAN_W-1:0] chan;
        logic              diff;
        logic              bipolar;
    } asp_conv_type;

    typedef struct packed {
        logic              cs_d;
        logic              sclk_d;
        logic              start_d;
        logic              rose;
        logic [2:0]        bit_cnt;
        logic [6:0]        shift_in;
        logic              second;
        logic [1:0]        range_sel;
        logic [1:0]        mode;
        logic              top_start;
        logic [PAIR_N-1:0] uni;
        logic [PAIR_N-1:0] bip;
        logic [CHAN_W-1:0] chan;
        logic              conv_start;
        logic [WORD_W-1:0] out_shift;
        logic [4:0]        out_cnt;
        logic [RES_W-1:0]  res_word;
        logic              res_full;
        logic              eoc_n;
    } asp_state_type;
endpackage

// *** hw/asp_sync.sv ***
/*
 * Two-flop synchroniser bank for pins from outside the system clock domain.
 * Assumes each bit is an independent level; no bus coherency is given.
 */
`timescale 1ns/1ps
module asp_sync #(
    parameter int          W         = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta     <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// *** hw/asp_serial_port.sv ***
/*
 * Serial port and control pins of a multichannel 10-bit converter, device side.
 * Assumes the converter core sits on sys_clk and returns results as a one-cycle strobe;
 * serial clock, chip select, data in and the start pin arrive asynchronously.
 */
`timescale 1ns/1ps
module asp_serial_port
    import asp_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // Serial pins
    input  wire logic              cs_n,
    input  wire logic              sclk,
    input  wire logic              din,
    output logic                   dout,
    output logic                   dout_oe,
    output logic                   eoc_n,
    // Shared top pin as conversion start
    input  wire logic              conversion_start_n,
    output logic                   analog_input_top_en,
    // Converter core
    output asp_conv_type           conv,
    output logic [1:0]             clock_mode_select,
    input  wire logic              res_valid,
    input  wire logic [RES_W-1:0]  res_data
);
    asp_state_type s;
    asp_state_type n;
    logic [3:0]    sy;
    logic          cs_s;
    logic          sclk_s;
    logic          din_s;
    logic          start_s;
    logic          cs_fall;
    logic          sclk_rise;
    logic          sclk_fall;
    logic          start_fall;
    logic          byte_done;
    logic [7:0]    byte_in;

    function automatic logic [2:0] pair_of(input logic [CHAN_W-1:0] ch);
        pair_of = ch[CHAN_W-1:1];
    endfunction

    // Pins pass two flops before use
    asp_sync #(.W(4), .RESET_VAL(4'hB)) u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in ({conversion_start_n, din, sclk, cs_n}),
        .sync_out (sy)
    );
    assign cs_s    = sy[0];
    assign sclk_s  = sy[1];
    assign din_s   = sy[2];
    assign start_s = sy[3];

    // Edge finding on the sampled pins
    // serial clock edges gated by chip select
    assign cs_fall    = s.cs_d & ~cs_s;
    assign sclk_rise  = ~s.sclk_d & sclk_s & ~cs_s;
    assign sclk_fall  = s.sclk_d & ~sclk_s & ~cs_s;
    assign start_fall = s.start_d & ~start_s;
    assign byte_done  = sclk_rise && (s.bit_cnt == LAST_BIT);
    assign byte_in    = {s.shift_in, din_s};

    // Next-state logic
    always_comb begin
        n            = s;
        n.conv_start = 1'b0;
        n.cs_d       = cs_s;
        n.sclk_d     = sclk_s;
        n.start_d    = start_s;
        if (cs_fall) begin
            n.bit_cnt   = '0;
            n.second    = 1'b0;
            n.rose      = 1'b0;
            n.out_cnt   = '0;
            n.out_shift = s.res_full ? {{LEAD_ZEROS{1'b0}}, s.res_word, {SUB_BITS{1'b0}}} : '0;
            n.eoc_n     = 1'b1;
        end
        if (start_fall && s.top_start) begin
            n.eoc_n = 1'b1;
            if (s.mode == MODE_PIN_SCAN || s.mode == MODE_PIN_EACH) begin
                n.conv_start = 1'b1;
            end
        end
        if (sclk_rise) begin
            n.rose     = 1'b1;
            n.shift_in = byte_in[6:0];
            n.bit_cnt  = s.bit_cnt + 3'h1;
        end
        if (byte_done) begin
            if (s.second) begin
                n.second = 1'b0;
                if (s.range_sel == RSEL_UNI) begin
                    n.uni = byte_in;
                end else if (s.range_sel == RSEL_BIP) begin
                    n.bip = byte_in;
                end
            end else if (byte_in[CMD_CONV_BIT]) begin
                n.chan = byte_in[CHAN_LSB +: CHAN_W];
                // top channel unusable as analog while pin is a start
                n.conv_start = !(s.top_start && n.chan == TOP_CHAN);
            end else if (byte_in[CMD_SETUP_BIT]) begin
                n.mode      = byte_in[MODE_LSB +: 2];
                n.top_start = byte_in[TOP_PIN_BIT];
                n.range_sel = byte_in[RSEL_LSB +: 2];
                n.second    = (byte_in[RSEL_LSB +: 2] == RSEL_UNI) || (byte_in[RSEL_LSB +: 2] == RSEL_BIP);
            end
        end
        // shift out on falling edge; the idle-high first fall is skipped
        if (sclk_fall && s.rose) begin
            n.out_shift = {s.out_shift[WORD_W-2:0], 1'b0};
            n.out_cnt   = s.out_cnt + 5'h01;
            if (s.out_cnt == LAST_OUT_BIT) begin
                n.res_full = 1'b0;
            end
        end
        // new result wins over a read-out clear
        if (res_valid) begin
            n.res_word = res_data;
            n.res_full = 1'b1;
            n.eoc_n    = 1'b0;
        end
        // held high in external clock mode
        if (n.mode == MODE_EXTCLK) begin
            n.eoc_n = 1'b1;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s           <= '0;
            s.cs_d      <= 1'b1;
            s.sclk_d    <= 1'b1;
            s.start_d   <= 1'b1;
            s.mode      <= MODE_RESET;
            s.uni       <= RANGE_RESET;
            s.bip       <= RANGE_RESET;
            s.eoc_n     <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // Outputs; pair settings looked up from the range registers
    // released while chip select is high
    assign dout_oe             = ~s.cs_d;
    assign dout                = s.out_shift[WORD_W-1];
    assign eoc_n               = s.eoc_n;
    assign clock_mode_select   = s.mode;
    assign analog_input_top_en = ~s.top_start;
    assign conv.start          = s.conv_start;
    assign conv.chan           = s.chan;
    assign conv.diff           = s.uni[pair_of(s.chan)] | s.bip[pair_of(s.chan)];
    assign conv.bipolar        = s.bip[pair_of(s.chan)];

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_oe_off;
        cs_s && $past(cs_s) |=> !dout_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("dout driven with select high");

    property p_idle_cnt;
        cs_s && s.cs_d |=> $stable(s.bit_cnt) && $stable(s.shift_in);
    endproperty
    a_idle_cnt: assert property (p_idle_cnt) else $error("serial state moved while deselected");

    property p_cnt_clear;
        cs_fall && !sclk_rise |=> s.bit_cnt == 3'h0;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("bit counter not cleared on select");

    property p_dout_edge;
        $changed(dout) |-> $past(sclk_fall || cs_fall);
    endproperty
    a_dout_edge: assert property (p_dout_edge) else $error("dout moved off a falling edge");

    property p_eoc_valid;
        $fell(eoc_n) |-> s.res_full && $past(res_valid);
    endproperty
    a_eoc_valid: assert property (p_eoc_valid) else $error("eoc low without a result");

    property p_eoc_rise;
        cs_fall && !res_valid |=> eoc_n;
    endproperty
    a_eoc_rise: assert property (p_eoc_rise) else $error("eoc not raised on select");

    property p_extclk;
        clock_mode_select == MODE_EXTCLK |-> eoc_n;
    endproperty
    a_extclk: assert property (p_extclk) else $error("eoc low in external clock mode");

    property p_mode_load;
        byte_done && !s.second && !byte_in[CMD_CONV_BIT] && byte_in[CMD_SETUP_BIT]
            |=> clock_mode_select == $past(byte_in[MODE_LSB +: 2]);
    endproperty
    a_mode_load: assert property (p_mode_load) else $error("mode not taken from bits 5:4");

    property p_single_uni;
        !conv.diff |-> !conv.bipolar;
    endproperty
    a_single_uni: assert property (p_single_uni) else $error("single-ended channel bipolar");

    property p_top_excl;
        conv.start && conv.chan == TOP_CHAN && !$past(start_fall) |-> analog_input_top_en;
    endproperty
    a_top_excl: assert property (p_top_excl) else $error("top pin used as both start and analog");

    property p_res_word;
        res_valid |=> s.res_full && s.res_word == $past(res_data);
    endproperty
    a_res_word: assert property (p_res_word) else $error("10-bit result not held");
endmodule

// *** sim/asp_master_model.sv ***
/*
 * Behavioural serial master for the converter port.
 * Assumes sclk idles at sclk_idle, low unless the bench sets it high, and is only toggled inside a frame.
 */
`timescale 1ns/1ps
module asp_master_model (
    // Pins toward the port
    output logic      cs_n,
    output logic      sclk,
    output logic      din,
    // Answer from the port
    input  wire logic dout
);
    logic sclk_idle; // Idle level of the clock, set by the bench

    // Idle pins
    initial begin
        sclk_idle = 1'b0;
        cs_n      = 1'b1;
        sclk      = 1'b0;
        din       = 1'b0;
    end

    // Frame of n bits MSB first; sel low keeps select high
    task automatic xfer(input logic [15:0] tx, input int n, input logic sel, output logic [15:0] rx);
        rx   = '0;
        sclk = sclk_idle; // Clock settles before select falls
        #40;
        cs_n = ~sel;
        #40;
        sclk = 1'b0; // Leading fall of an idle-high clock
        for (int i = 0; i < n; i++) begin
            din = tx[n-1-i];
            #24 sclk = 1'b1;
            rx = {rx[14:0], dout}; // Taken at the rise
            #24 sclk = 1'b0;
        end
        #24 cs_n = 1'b1;
        din = ~din; // Released line must not keep the last bit
        #40;
        sclk = sclk_idle;
    endtask
endmodule

// *** sim/asp_serial_port_test.sv ***
/*
 * Self-checking bench for the serial port and control pins.
 * Assumes the master model drives the pins and the bench plays the core.
 */
`timescale 1ns/1ps
module asp_serial_port_test;
    import asp_pkg::*;
    logic             sys_clk, rst_n, cs_n, sclk, din, dout, dout_oe, eoc_n;
    logic             conversion_start_n, analog_input_top_en, res_valid;
    logic [RES_W-1:0] res_data;
    logic [1:0]       clock_mode_select;
    logic [15:0]      rx;
    asp_conv_type     conv, last;
    int               fails, total_checks, starts, base;

    asp_serial_port uut (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din),
        .dout(dout), .dout_oe(dout_oe), .eoc_n(eoc_n), .conversion_start_n(conversion_start_n),
        .analog_input_top_en(analog_input_top_en), .conv(conv),
        .clock_mode_select(clock_mode_select), .res_valid(res_valid), .res_data(res_data));
    // Released output shows the inverse, so a stale bit cannot pass
    asp_master_model u_master (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout_oe ? dout : ~dout));

    // 250 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Start is one cycle wide; read it mid-cycle where it has settled
    always @(negedge sys_clk) begin
        if (conv.start === 1'b1) begin
            starts++;
            last = conv;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic frame(input logic [15:0] tx, input int n);
        u_master.xfer(tx, n, 1'b1, rx);
        repeat (8) @(negedge sys_clk);
    endtask

    // One command frame and the count of requests it made
    task automatic cmd(input logic [7:0] b, input int exp_n);
        int s0;
        s0 = starts;
        frame({8'h00, b}, 8);
        chk(16'(starts - s0), 16'(exp_n));
    endtask

    task automatic result(input logic [RES_W-1:0] v);
        @(negedge sys_clk);
        res_data  = v;
        res_valid = 1'b1;
        @(negedge sys_clk);
        res_valid = 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic finish_test();
        if (fails == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard, well past the expected run
    initial begin
        #300000;
        fails++;
        finish_test();
    end

    initial begin
        fails = 0;
        total_checks = 0;
        starts = 0;
        rst_n = 1'b0;
        res_valid = 1'b0;
        res_data = '0;
        conversion_start_n = 1'b1;
        repeat (12) @(negedge sys_clk);
        chk(16'({clock_mode_select, dout_oe, eoc_n, analog_input_top_en}), 16'h0013);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk(16'({clock_mode_select, dout_oe, eoc_n, analog_input_top_en}), 16'h0013);
        // Every channel, single-ended
        for (int c = 0; c < 16; c++) begin
            cmd({1'b1, c[3:0], 3'b000}, 1);
            chk(16'(last.chan), 16'(c[3:0]));
            chk(16'({last.diff, last.bipolar}), 16'h0000);
        end
        // Two commands back to back in one frame
        frame(16'h8088, 16);
        chk(16'(last.chan), 16'h0001);
        // Partial byte dropped; next frame starts aligned
        frame(16'h001F, 5);
        cmd(8'h88, 1);
        chk(16'(last.chan), 16'h0001);
        // Clock toggled with select high is ignored
        u_master.xfer(16'h0080, 8, 1'b0, rx);
        chk(16'(starts), 16'h0013);
        chk(16'(dout_oe), 16'h0000);
        // Result read out
        result(10'h2A5);
        chk(16'(eoc_n), 16'h0000);
        fork
            frame(16'h0000, 16);
            begin
                #100;
                chk(16'({eoc_n, dout_oe}), 16'h0003);
            end
        join
        chk(rx, 16'h0A94);
        frame(16'h0000, 16);
        chk(rx, 16'h0000);
        // All clock modes
        for (int m = 0; m < 4; m++) begin
            cmd({2'b01, m[1:0], 4'h0}, 0);
            chk(16'(clock_mode_select), 16'(m[1:0]));
        end
        result(10'h155);
        chk(16'(eoc_n), 16'h0001);
        // Top pin as start input
        cmd(8'h58, 0);
        chk(16'(analog_input_top_en), 16'h0000);
        cmd(8'hF8, 0);
        result(10'h0FF);
        chk(16'(eoc_n), 16'h0000);
        base = starts;
        conversion_start_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk(16'(eoc_n), 16'h0001);
        chk(16'(starts - base), 16'h0001);
        conversion_start_n = 1'b1;
        cmd(8'h50, 0);
        chk(16'(analog_input_top_en), 16'h0001);
        // Pin not configured as start: its fall requests nothing
        base = starts;
        conversion_start_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        conversion_start_n = 1'b1;
        chk(16'(starts - base), 16'h0000);
        cmd(8'hF8, 1);
        // Idle-high clock from here on; its leading fall must not shift
        u_master.sclk_idle = 1'b1;
        result(10'h3C3);
        frame(16'h0000, 16);
        chk(rx, 16'h0F0C);
        // Range bytes: pair 0 unipolar, pair 1 bipolar
        frame(16'h6101, 16);
        frame(16'h6202, 16);
        cmd(8'h88, 1);
        chk(16'({last.diff, last.bipolar}), 16'h0002);
        cmd(8'h90, 1);
        chk(16'({last.diff, last.bipolar}), 16'h0003);
        cmd(8'hA0, 1);
        chk(16'({last.diff, last.bipolar}), 16'h0000);
        finish_test();
    end
endmodule
